// ===== hdl/sdsc_descrambler.sv
`timescale 1ns/1ns
module sdsc_descrambler (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic rx_bit_i,
  input wire logic rx_valid_i,
  input wire logic hec_pred_i,
  input wire logic hec8_mark_i,
  input wire logic acquire_i,
  output logic data_o,
  output logic data_valid_o,
  output logic cmp_done_o,
  output logic mismatch_o,
  output logic agree_o,
  output logic corrected_o
);

  // ---------------------------------------------------------------
  // generator link
  // ---------------------------------------------------------------
  sdsc_gen_if gen_bus ();

  sdsc_gen u_gen (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .gen(gen_bus.gen)
  );

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  sdsc_pkg::sdsc_state_t state_q;
  sdsc_pkg::sdsc_state_t state_d;
  logic [8:0] phase_q;
  logic [8:0] phase_d;

  // ---------------------------------------------------------------
  // single-bit stores
  // ---------------------------------------------------------------
  // upper store holds the conveyed sample, lower store the local one
  logic upper_q;
  logic upper_d;
  logic lower_q;
  logic lower_d;

  // ---------------------------------------------------------------
  // outputs held in flip-flops
  // ---------------------------------------------------------------
  logic data_q;
  logic data_d;
  logic data_valid_q;
  logic data_valid_d;
  logic cmp_done_q;
  logic cmp_done_d;
  logic mismatch_q;
  logic mismatch_d;
  logic agree_q;
  logic agree_d;
  logic corrected_q;
  logic corrected_d;

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  logic conveyed;
  logic first_cmp;
  logic second_cmp;
  logic cmp_now;
  logic cmp_diff;

  function automatic logic recover(input logic rx, input logic pred);
    recover = rx ^ pred;
  endfunction

  // ---------------------------------------------------------------
  // half-cell phase decode, shared by the compare and the stores
  // ---------------------------------------------------------------
  function automatic logic at_phase(input sdsc_pkg::sdsc_state_t st, input logic [8:0] ph,
      input logic [8:0] want);
    at_phase = (st == sdsc_pkg::SDSC_HALF) && (ph == want);
  endfunction

  always_comb begin
    conveyed = recover(rx_bit_i, hec_pred_i);
    first_cmp = hec8_mark_i;
    second_cmp = at_phase(state_q, phase_q, sdsc_pkg::PHASE_SECOND_CMP);
    cmp_now = first_cmp || second_cmp;
    // the multiplexer picks the live conveyed sample and the held local sample at t, and the held pair at t+212
    if (first_cmp) begin
      cmp_diff = conveyed ^ lower_q;
    end else begin
      cmp_diff = upper_q ^ lower_q;
    end
  end

  // correction only while acquiring; in sync the compare just checks agreement
  assign gen_bus.correct = cmp_now && cmp_diff && acquire_i;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    // a fresh mark always restarts the half-cell count
    // marks under 213 bits apart drop the pending second compare; nothing is queued
    if (hec8_mark_i) begin
      state_d = sdsc_pkg::SDSC_HALF;
      phase_d = sdsc_pkg::PHASE_CAPTURE;
    end else begin
      case (state_q)
        sdsc_pkg::SDSC_WAIT: begin
          phase_d = '0;
        end
        sdsc_pkg::SDSC_HALF: begin
          if (phase_q == sdsc_pkg::PHASE_RELOAD) begin
            state_d = sdsc_pkg::SDSC_WAIT;
            phase_d = '0;
          end else begin
            phase_d = phase_q + 9'h001;
          end
        end
        default: begin
          state_d = sdsc_pkg::SDSC_WAIT;
          phase_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= sdsc_pkg::SDSC_WAIT;
      phase_q <= '0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
    end
  end

  // ---------------------------------------------------------------
  // sample stores
  // ---------------------------------------------------------------
  always_comb begin
    upper_d = upper_q;
    lower_d = lower_q;
    if (at_phase(state_q, phase_q, sdsc_pkg::PHASE_CAPTURE)) begin
      // HEC bit 7 sample and matching local sample, frozen for 211 bits
      upper_d = conveyed;
      lower_d = gen_bus.sample;
    end else if (at_phase(state_q, phase_q, sdsc_pkg::PHASE_RELOAD)) begin
      // this local sample lines up with the next cell's HEC bit 8 sample
      lower_d = gen_bus.sample;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      // both stores clear, so the first compare after reset is made against zero
      upper_q <= 1'b0;
      lower_q <= 1'b0;
    end else begin
      upper_q <= upper_d;
      lower_q <= lower_d;
    end
  end

  // ---------------------------------------------------------------
  // payload path and status
  // ---------------------------------------------------------------
  always_comb begin
    // data trails the line by one bit period
    data_d = rx_bit_i ^ gen_bus.sample;
    data_valid_d = rx_valid_i;
    cmp_done_d = cmp_now;
    mismatch_d = cmp_now && cmp_diff;
    // reports the edge that moved the generator, one cycle late
    corrected_d = gen_bus.correct;
    agree_d = agree_q;
    // agreement is sticky between comparisons so users can watch a level
    if (cmp_now) begin
      agree_d = !cmp_diff;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_q <= 1'b0;
      data_valid_q <= 1'b0;
      cmp_done_q <= 1'b0;
      mismatch_q <= 1'b0;
      agree_q <= 1'b0;
      corrected_q <= 1'b0;
    end else begin
      data_q <= data_d;
      data_valid_q <= data_valid_d;
      cmp_done_q <= cmp_done_d;
      mismatch_q <= mismatch_d;
      agree_q <= agree_d;
      corrected_q <= corrected_d;
    end
  end

  assign data_o = data_q;
  assign data_valid_o = data_valid_q;
  assign cmp_done_o = cmp_done_q;
  assign mismatch_o = mismatch_q;
  assign agree_o = agree_q;
  assign corrected_o = corrected_q;

endmodule // sdsc_descrambler

// ===== hdl/sdsc_gen.sv
`timescale 1ns/1ns
module sdsc_gen (
  input wire logic core_clk_i,
  input wire logic reset_i,
  sdsc_gen_if.gen gen
);

  logic [30:0] state_q;
  logic [30:0] state_d;
  logic fb;

  // ---------------------------------------------------------------
  // recursive generator with advanced feed-forward output
  // ---------------------------------------------------------------
  always_comb begin
    fb = ^(state_q & sdsc_pkg::GEN_FEEDBACK);
    state_d = {state_q[29:0], fb};
    // correction is folded into the next state so the sequence jumps in one bit
    if (gen.correct) begin
      state_d = state_d ^ sdsc_pkg::GEN_CORR_VEC;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= sdsc_pkg::GEN_SEED;
    end else begin
      state_q <= state_d;
    end
  end

  assign gen.sample = ^(state_q & sdsc_pkg::GEN_ADV_TAPS);

endmodule // sdsc_gen

// ===== hdl/sdsc_gen_if.sv
`timescale 1ns/1ns
interface sdsc_gen_if;
  logic sample;
  logic correct;

  modport ctrl (input sample, output correct);
  modport gen (output sample, input correct);
endinterface

// ===== hdl/sdsc_pkg.sv
package sdsc_pkg;

  // ---------------------------------------------------------------
  // generator geometry
  // ---------------------------------------------------------------
  localparam int unsigned GEN_WIDTH = 31;

  // seed loaded at reset; any non-zero pattern keeps the generator alive
  localparam logic [30:0] GEN_SEED = 31'h0000_0001;

  // feedback taps of the recursive generator (x^31 + x^28 + 1)
  localparam logic [30:0] GEN_FEEDBACK = 31'h4800_0000;

  // feed-forward tap mask that yields the 211-sample advanced output
  localparam logic [30:0] GEN_ADV_TAPS = 31'h0000_0001;

  // constant correction vector added to the state on a mismatch while acquiring
  localparam logic [30:0] GEN_CORR_VEC = 31'h0000_0001;

  // ---------------------------------------------------------------
  // cell timing, in bit periods after the first conveyed sample
  // ---------------------------------------------------------------
  localparam int unsigned PHASE_WIDTH = 9;
  localparam logic [8:0] PHASE_CAPTURE = 9'h001;
  localparam logic [8:0] PHASE_HOLD = 9'h0D3;
  localparam logic [8:0] PHASE_SECOND_CMP = 9'h0D4;
  localparam logic [8:0] PHASE_RELOAD = 9'h0D5;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    SDSC_WAIT = 1'b0,
    SDSC_HALF = 1'b1
  } sdsc_state_t;

endpackage

// ===== testbench/sdsc_descrambler_asserts.sv
`timescale 1ns/1ns
module sdsc_descrambler_asserts (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic rx_valid_i,
  input wire logic hec8_mark_i,
  input wire logic acquire_i,
  input wire logic data_valid_o,
  input wire logic cmp_done_o,
  input wire logic mismatch_o,
  input wire logic agree_o,
  input wire logic corrected_o
);
  // ---------------------------------------------------------------
  // bit periods since the last mark, parked at 511 when idle
  // ---------------------------------------------------------------
  logic [8:0] since_d;
  logic [8:0] since_q;
  always_comb begin
    since_d = (since_q == 9'h1FF) ? since_q : since_q + 9'h001;
    if (hec8_mark_i) since_d = 9'h001;
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) since_q <= 9'h1FF;
    else since_q <= since_d;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  AST_FIRST_CMP: assert property (hec8_mark_i |=> cmp_done_o)
    else $error("first compare missing");
  AST_SECOND_CMP: assert property (since_q == 9'h0D5 |-> cmp_done_o)
    else $error("second compare missing");
  AST_CMP_PHASE: assert property (cmp_done_o |-> since_q == 9'h001 || since_q == 9'h0D5)
    else $error("compare at wrong phase");
  AST_MISS_PULSE: assert property (mismatch_o |-> cmp_done_o)
    else $error("mismatch without compare");
  AST_AGREE: assert property (cmp_done_o |-> agree_o == !mismatch_o)
    else $error("agree wrong");
  AST_AGREE_HOLD: assert property (!cmp_done_o |-> $stable(agree_o))
    else $error("agree moved");
  AST_CORR_ACQ: assert property (cmp_done_o && mismatch_o && $past(acquire_i) |-> corrected_o)
    else $error("correction missing");
  AST_NO_CORR: assert property (corrected_o |-> $past(acquire_i) && mismatch_o)
    else $error("stray correction");
  AST_VALID: assert property (rx_valid_i |=> data_valid_o)
    else $error("valid lost");
  COV_MARK: cover property (hec8_mark_i);
  COV_SECOND: cover property (since_q == 9'h0D5 && mismatch_o);
  COV_CORR: cover property (corrected_o);
endmodule // sdsc_descrambler_asserts

// ===== testbench/sdsc_descrambler_test.sv
`timescale 1ns/1ns
module sdsc_descrambler_test;
  logic clk, reset_i, en, acq, xmark, rx_bit, pred, tmark, m1, m2, b1, b2;
  logic [3:0] hec;
  logic [30:0] ref_q;
  logic [30:0] ref_cur;
  logic ref_data;
  logic data_o, data_valid_o, cmp_done_o, mismatch_o, agree_o, corrected_o;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // {acquire, rx8, pred8, rx7, pred7}; row 0 is the reference cell
  logic [4:0] rows [6] = '{5'h00, 5'h0A, 5'h05, 5'h0C, 5'h03, 5'h1A};
  sdsc_tx_model u_tx (.core_clk_i(clk), .en_i(en), .hec_i(hec), .rx_bit_o(rx_bit),
    .hec_pred_o(pred), .mark_o(tmark));
  sdsc_descrambler uut (.core_clk_i(clk), .reset_i(reset_i), .rx_bit_i(rx_bit),
    .rx_valid_i(en), .hec_pred_i(pred), .hec8_mark_i(tmark | xmark), .acquire_i(acq),
    .data_o(data_o), .data_valid_o(data_valid_o), .cmp_done_o(cmp_done_o),
    .mismatch_o(mismatch_o), .agree_o(agree_o), .corrected_o(corrected_o));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string nm, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // reference generator from the package constants; a reported correction is folded in
  assign ref_cur = ref_q ^ (corrected_o ? sdsc_pkg::GEN_CORR_VEC : 31'h0000_0000);
  always @(posedge clk) begin
    if (reset_i) begin
      ref_q <= sdsc_pkg::GEN_SEED;
      ref_data <= 1'b0;
    end else begin
      ref_q <= {ref_cur[29:0], ^(ref_cur & sdsc_pkg::GEN_FEEDBACK)};
      ref_data <= rx_bit ^ (^(ref_cur & sdsc_pkg::GEN_ADV_TAPS));
    end
  end
  always @(negedge clk) begin
    if (!reset_i) check("data", data_o, ref_data);
  end
  task automatic do_reset();
    @(negedge clk) reset_i <= 1'b1;
    repeat (8) @(negedge clk);
    check("rst", |{data_o, data_valid_o, cmp_done_o, mismatch_o, agree_o, corrected_o}, 1'b0);
    reset_i <= 1'b0;
  endtask
  // one cell from a fresh reset; without acquire the generator depends on time alone
  task automatic run_cell(input logic [4:0] r);
    acq <= r[4];
    hec <= r[3:0];
    do_reset();
    en <= 1'b1;
    @(negedge clk);
    check("cmp1", cmp_done_o, 1'b1);
    check("valid", data_valid_o, 1'b1);
    m1 = mismatch_o;
    check("corr1", corrected_o, r[4] & m1);
    repeat (212) @(negedge clk);
    check("cmp2", cmp_done_o, 1'b1);
    m2 = mismatch_o;
    check("agree", agree_o, ~m2);
    check("corr2", corrected_o, r[4] & m2);
    en <= 1'b0;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    {reset_i, en, acq, xmark, hec} = {1'b1, 1'b0, 1'b0, 1'b0, 4'h0};
    for (int i = 0; i < 6; i++) begin
      run_cell(rows[i]);
      if (i == 0) {b1, b2} = {m1, m2};
      else if (!rows[i][4]) begin
        check("hec8", m1 ^ b1, rows[i][3] ^ rows[i][2]);
        check("hec7", m2 ^ b2, rows[i][1] ^ rows[i][0]);
      end
    end
    // a mark 100 bits into a cell drops the old second compare
    acq <= 1'b0;
    do_reset();
    en <= 1'b1;
    repeat (100) @(negedge clk);
    xmark <= 1'b1;
    @(negedge clk) xmark <= 1'b0;
    check("remark", cmp_done_o, 1'b1);
    repeat (112) @(negedge clk);
    check("dropped", cmp_done_o, 1'b0);
    repeat (100) @(negedge clk);
    check("recmp", cmp_done_o, 1'b1);
    // local sample live 213 bits after the re-mark must meet the next regular mark
    b1 = ^(ref_q & sdsc_pkg::GEN_ADV_TAPS);
    repeat (112) @(negedge clk);
    check("cmp3", cmp_done_o, 1'b1);
    check("reload", mismatch_o, hec[3] ^ hec[2] ^ b1);
    do_reset();
    en <= 1'b0;
    finish_test();
  end
endmodule // sdsc_descrambler_test
bind sdsc_descrambler sdsc_descrambler_asserts u_asserts (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .rx_valid_i(rx_valid_i), .hec8_mark_i(hec8_mark_i),
  .acquire_i(acquire_i), .data_valid_o(data_valid_o), .cmp_done_o(cmp_done_o),
  .mismatch_o(mismatch_o), .agree_o(agree_o), .corrected_o(corrected_o));

// ===== testbench/sdsc_tx_model.sv
`timescale 1ns/1ns
module sdsc_tx_model #(
  parameter int unsigned CELL_BITS = 424
) (
  input wire logic core_clk_i,
  input wire logic en_i,
  input wire logic [3:0] hec_i,
  output logic rx_bit_o,
  output logic hec_pred_o,
  output logic mark_o
);
  logic [8:0] pos_q = 9'h000;
  always @(negedge core_clk_i) begin
    if (!en_i || pos_q == 9'(CELL_BITS - 1)) pos_q <= 9'h000;
    else pos_q <= pos_q + 9'h001;
  end
  // hec8 in the mark bit, hec7 one bit later; payload toggles so nothing lingers
  assign mark_o = en_i && pos_q == 9'h000;
  assign rx_bit_o = (pos_q == 9'h000) ? hec_i[3] : (pos_q == 9'h001) ? hec_i[1] : pos_q[0];
  assign hec_pred_o = (pos_q == 9'h000) ? hec_i[2] : (pos_q == 9'h001) ? hec_i[0] : ~pos_q[0];
endmodule // sdsc_tx_model
